// File: design/rfcp_command_port.sv
`timescale 1ns/1ns
module rfcp_command_port (
  input wire logic clock, // 100 MHz system clock
  input wire logic reset, // async, active high
  input wire logic clock_enable, // freezes all state when low
  input wire logic device_select_n, // serial select pin, active low
  input wire logic serial_clock_pin, // serial clock pin from host
  input wire logic serial_in_pin, // serial data pin from host
  input wire logic freq_select_bit2, // frequency-select pin 2
  input wire logic freq_select_bit1, // frequency-select pin 1
  input wire logic freq_select_bit0, // frequency-select pin 0
  input wire logic crystal_clock_pin, // crystal oscillator clock
  input wire logic lock_detect_pin, // synthesizer lock detect
  input wire logic first_pin_use_level, // 1: first pin shows first_pin_level in serial mode
  input wire logic first_pin_level, // general output level for first pin
  input wire logic [2:0] clock_div_code, // 0..4 selects 1,2,4,8,16
  input wire logic gpo2_use_level, // 1: deselected second pin shows gpo2_level in serial mode
  input wire logic gpo2_level, // general output level for second pin
  output logic first_output_pin, // first general-purpose output
  output logic second_output_pin, // read data or general output
  output logic master_reset_n, // internal master reset, active low
  output logic serial_mode // high when serial mode selected
);
  typedef struct packed {
    rfcp_pkg::rfcp_pins_s pin1;
    rfcp_pkg::rfcp_pins_s pin2;
    rfcp_pkg::rfcp_pins_s pin3;
    rfcp_pkg::rfcp_state_e state;
    logic [2:0] bit_cnt;
    logic [7:0] rx;
    logic [7:0] tx;
    logic [7:0] addr;
    logic rd_go;
    logic rd_wait;
    logic [7:0] rd_addr;
    rfcp_pkg::rfcp_wr_s wr;
    logic ra_pending;
    logic ra_second;
    logic first_pin;
    logic second_pin;
    logic mrst_n;
    logic serial;
  } rfcp_core_s;

  rfcp_core_s s_reg;
  rfcp_core_s s_next;
  logic [7:0] rd_data;
  logic div_clk;
  logic serial_now;
  logic sel_low;
  logic sel_fall;
  logic sel_rise;
  logic sclk_rise;
  logic sclk_fall;
  logic xtal_rise;
  logic byte_done;
  logic [7:0] in_byte;

  function automatic logic [7:0] next_addr(input logic [7:0] a);
    next_addr = a + 8'h01;
  endfunction : next_addr

  // only second and third stages feed logic; first stage is the synchroniser
  assign serial_now = s_reg.pin2.freq == rfcp_pkg::FREQ_SERIAL;
  assign sel_low = ~s_reg.pin2.select_n && serial_now;
  assign sel_fall = ~s_reg.pin2.select_n && s_reg.pin3.select_n;
  assign sel_rise = s_reg.pin2.select_n && ~s_reg.pin3.select_n;
  assign sclk_rise = s_reg.pin2.sclk && ~s_reg.pin3.sclk;
  assign sclk_fall = ~s_reg.pin2.sclk && s_reg.pin3.sclk;
  assign xtal_rise = s_reg.pin2.crystal && ~s_reg.pin3.crystal;
  assign byte_done = sel_low && sclk_rise && s_reg.bit_cnt == rfcp_pkg::BIT_LAST;
  assign in_byte = {s_reg.rx[6:0], s_reg.pin2.sdi};

  always_comb
  begin
    s_next = s_reg;
    s_next.pin1 = '{select_n: device_select_n, sclk: serial_clock_pin,
                    sdi: serial_in_pin, crystal: crystal_clock_pin,
                    lock: lock_detect_pin,
                    freq: {freq_select_bit2, freq_select_bit1, freq_select_bit0}};
    s_next.pin2 = s_reg.pin1;
    s_next.pin3 = s_reg.pin2;
    s_next.rd_go = 1'b0;
    s_next.rd_wait = s_reg.rd_go;
    s_next.wr.en = 1'b0;
    s_next.serial = serial_now;
    if (!serial_now || sel_rise)
    begin
      // a half-shifted byte is simply dropped
      s_next.state = rfcp_pkg::RFCP_IDLE;
      s_next.bit_cnt = 3'h0;
      s_next.ra_pending = serial_now && s_reg.state == rfcp_pkg::RFCP_RA_STREAM
                          && !s_reg.ra_second;
      s_next.ra_second = 1'b0;
    end
    else if (sel_fall)
    begin
      s_next.bit_cnt = 3'h0;
      s_next.tx = rfcp_pkg::FILL_BYTE;
      s_next.mrst_n = 1'b1;
      if (s_reg.ra_pending)
      begin
        // last prefetch of the first period never left the pin; resend it first
        s_next.state = rfcp_pkg::RFCP_RA_STREAM;
        s_next.rd_go = 1'b1;
        s_next.rd_addr = s_reg.rd_addr;
        s_next.addr = next_addr(s_reg.rd_addr);
        s_next.ra_pending = 1'b0;
        s_next.ra_second = 1'b1;
      end
    end
    else if (sel_low)
    begin
      if (sclk_rise)
      begin
        s_next.rx = in_byte;
        s_next.bit_cnt = s_reg.bit_cnt + 3'h1;
      end
      else if (sclk_fall && s_reg.bit_cnt != 3'h0)
      begin
        // no shift on the falling edge that closes a byte: next byte's msb stays
        s_next.tx = {s_reg.tx[6:0], 1'b0};
      end
      if (s_reg.rd_wait)
      begin
        s_next.tx = rd_data;
      end
      if (byte_done)
      begin
        unique case (s_reg.state)
          rfcp_pkg::RFCP_IDLE:
          begin
            if (in_byte == rfcp_pkg::CMD_WRITE)
            begin
              s_next.state = rfcp_pkg::RFCP_WR_ADDR;
            end
            else if (in_byte == rfcp_pkg::CMD_READ)
            begin
              s_next.state = rfcp_pkg::RFCP_RD_ADDR;
            end
            else if (in_byte == rfcp_pkg::CMD_READ_ALL)
            begin
              s_next.state = rfcp_pkg::RFCP_RA_ADDR;
            end
            else
            begin
              s_next.state = rfcp_pkg::RFCP_SKIP;
              if (in_byte == rfcp_pkg::CMD_RESET)
              begin
                s_next.mrst_n = 1'b0;
              end
            end
          end
          rfcp_pkg::RFCP_WR_ADDR:
          begin
            s_next.addr = in_byte;
            s_next.state = rfcp_pkg::RFCP_WR_DATA;
          end
          rfcp_pkg::RFCP_WR_DATA:
          begin
            s_next.wr = '{en: 1'b1, addr: s_reg.addr, data: in_byte};
            s_next.addr = next_addr(s_reg.addr);
          end
          rfcp_pkg::RFCP_RD_ADDR:
          begin
            // any address order; the closing filler byte reads harmlessly
            s_next.rd_go = 1'b1;
            s_next.rd_addr = in_byte;
          end
          rfcp_pkg::RFCP_RA_ADDR:
          begin
            s_next.rd_go = 1'b1;
            s_next.rd_addr = in_byte;
            s_next.addr = next_addr(in_byte);
            s_next.state = rfcp_pkg::RFCP_RA_STREAM;
          end
          rfcp_pkg::RFCP_RA_STREAM:
          begin
            s_next.rd_go = 1'b1;
            s_next.rd_addr = s_reg.addr;
            s_next.addr = next_addr(s_reg.addr);
          end
          rfcp_pkg::RFCP_SKIP:
          begin
            s_next.state = rfcp_pkg::RFCP_SKIP;
          end
          default:
          begin
            s_next.state = rfcp_pkg::RFCP_IDLE;
          end
        endcase
      end
    end
    if (serial_now)
    begin
      s_next.first_pin = first_pin_use_level ? first_pin_level : div_clk;
      if (!s_reg.pin2.select_n)
      begin
        s_next.second_pin = s_reg.tx[7];
      end
      else
      begin
        s_next.second_pin = gpo2_use_level ? gpo2_level : s_reg.pin2.lock;
      end
    end
    else
    begin
      s_next.first_pin = s_reg.pin2.lock;
      s_next.second_pin = 1'b0;
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
      s_reg.mrst_n <= 1'b1;
      // select idles high, so no false select edge follows reset
      s_reg.pin1.select_n <= 1'b1;
      s_reg.pin2.select_n <= 1'b1;
      s_reg.pin3.select_n <= 1'b1;
    end
    else if (clock_enable)
    begin
      s_reg <= s_next;
    end
  end

  rfcp_regfile rfcp_regfile_inst (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .wr(s_reg.wr),
    .rd_en(s_reg.rd_go),
    .rd_addr(s_reg.rd_addr),
    .rd_data(rd_data)
  );

  rfcp_clock_divider rfcp_clock_divider_inst (
    .clock(clock),
    .reset(reset),
    .clock_enable(clock_enable),
    .xtal_level(s_reg.pin2.crystal),
    .xtal_rise(xtal_rise),
    .ratio(clock_div_code),
    .div_clk(div_clk)
  );

  assign first_output_pin = s_reg.first_pin;
  assign second_output_pin = s_reg.second_pin;
  assign master_reset_n = s_reg.mrst_n;
  assign serial_mode = s_reg.serial;

  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  sequence write_byte_s;
    clock_enable && byte_done && s_reg.state == rfcp_pkg::RFCP_WR_DATA;
  endsequence
  sequence read_issue_s;
    clock_enable && s_reg.rd_go && sel_low && !sel_rise;
  endsequence

  manual_first_pin_a: assert property (
    (clock_enable && !serial_now) |=> first_output_pin == $past(s_reg.pin2.lock))
    else $error("manual mode first pin is not lock detect");
  manual_second_off_a: assert property (
    (clock_enable && !serial_now) |=> !second_output_pin)
    else $error("second pin active in manual mode");
  first_clock_a: assert property (
    (clock_enable && serial_now && !first_pin_use_level) |=> first_output_pin == $past(div_clk))
    else $error("first pin does not follow divided clock");
  gpo2_idle_lock_a: assert property (
    (clock_enable && serial_now && s_reg.pin2.select_n && !gpo2_use_level)
    |=> second_output_pin == $past(s_reg.pin2.lock))
    else $error("second pin not lock detect while deselected");
  write_addr_step_a: assert property (
    write_byte_s |=> s_reg.wr.en && s_reg.wr.addr == $past(s_reg.addr)
                     && s_reg.addr == $past(s_reg.addr) + 8'h01)
    else $error("write address not stepped");
  read_load_a: assert property (
    read_issue_s ##1 (clock_enable && sel_low && !sel_rise && !sel_fall)
    ##1 clock_enable |-> s_reg.tx == $past(rd_data))
    else $error("read data not loaded for shifting");
  select_abort_a: assert property (
    (clock_enable && sel_rise) |=> s_reg.bit_cnt == 3'h0 && s_reg.state == rfcp_pkg::RFCP_IDLE)
    else $error("select rise did not abort");
  reset_cmd_a: assert property (
    (clock_enable && byte_done && s_reg.state == rfcp_pkg::RFCP_IDLE
     && in_byte == rfcp_pkg::CMD_RESET) |=> !master_reset_n)
    else $error("reset command did not assert master reset");
  reset_hold_a: assert property (
    (!master_reset_n && !(clock_enable && sel_fall && serial_now)) |=> !master_reset_n)
    else $error("master reset released before select fall");
  read_all_resume_a: assert property (
    (clock_enable && serial_now && sel_fall && !sel_rise && s_reg.ra_pending)
    |=> s_reg.rd_go && s_reg.state == rfcp_pkg::RFCP_RA_STREAM)
    else $error("read-all did not resume streaming");
  msb_first_a: assert property (
    (clock_enable && sel_low && sclk_rise && !sel_rise && !sel_fall)
    |=> s_reg.rx == {$past(s_reg.rx[6:0]), $past(s_reg.pin2.sdi)})
    else $error("serial input not shifted msb first");
endmodule : rfcp_command_port

// File: design/rfcp_pkg.sv
package rfcp_pkg;
  localparam logic [7:0] CMD_WRITE = 8'h01;
  localparam logic [7:0] CMD_READ = 8'h02;
  localparam logic [7:0] CMD_READ_ALL = 8'h03;
  localparam logic [7:0] CMD_RESET = 8'h04;
  localparam logic [7:0] FILL_BYTE = 8'h00;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] FREQ_SERIAL = 3'h0;
  localparam int DEPTH = 256;
  localparam logic [2:0] DIV_1 = 3'h0;
  localparam logic [2:0] DIV_2 = 3'h1;
  localparam logic [2:0] DIV_4 = 3'h2;
  localparam logic [2:0] DIV_8 = 3'h3;
  localparam logic [2:0] DIV_16 = 3'h4;

  typedef enum logic [2:0] {
    RFCP_IDLE = 3'h0,
    RFCP_WR_ADDR = 3'h1,
    RFCP_WR_DATA = 3'h2,
    RFCP_RD_ADDR = 3'h3,
    RFCP_RA_ADDR = 3'h4,
    RFCP_RA_STREAM = 3'h5,
    RFCP_SKIP = 3'h6
  } rfcp_state_e;

  typedef struct packed {
    logic select_n;
    logic sclk;
    logic sdi;
    logic crystal;
    logic lock;
    logic [2:0] freq;
  } rfcp_pins_s;

  typedef struct packed {
    logic en;
    logic [7:0] addr;
    logic [7:0] data;
  } rfcp_wr_s;
endpackage : rfcp_pkg

// File: design/rfcp_regfile.sv
`timescale 1ns/1ns
module rfcp_regfile (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic clock_enable, // freezes state when low
  input wire rfcp_pkg::rfcp_wr_s wr, // write strobe, address, data
  input wire logic rd_en, // read strobe
  input wire logic [7:0] rd_addr, // read address
  output logic [7:0] rd_data // read data, one cycle after rd_en
);
  typedef struct packed {
    logic [rfcp_pkg::DEPTH-1:0][7:0] mem;
    logic [7:0] rd_data;
  } rfcp_regfile_s;

  rfcp_regfile_s s_reg;
  rfcp_regfile_s s_next;

  // a read in the same cycle as a write to that address returns the old byte
  always_comb
  begin
    s_next = s_reg;
    if (wr.en)
    begin
      s_next.mem[wr.addr] = wr.data;
    end
    if (rd_en)
    begin
      s_next.rd_data = s_reg.mem[rd_addr];
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else if (clock_enable)
    begin
      s_reg <= s_next;
    end
  end

  assign rd_data = s_reg.rd_data;
endmodule : rfcp_regfile

// File: design/rfcp_clock_divider.sv
`timescale 1ns/1ns
module rfcp_clock_divider (
  input wire logic clock, // system clock
  input wire logic reset, // async, active high
  input wire logic clock_enable, // freezes state when low
  input wire logic xtal_level, // synchronised crystal level
  input wire logic xtal_rise, // one-cycle pulse per crystal rising edge
  input wire logic [2:0] ratio, // divide code
  output logic div_clk // divided crystal clock
);
  typedef struct packed {
    logic [3:0] cnt;
    logic clk_out;
  } rfcp_div_s;

  rfcp_div_s s_reg;
  rfcp_div_s s_next;

  function automatic logic [1:0] tap_index(input logic [2:0] code);
    case (code)
      rfcp_pkg::DIV_2: tap_index = 2'h0;
      rfcp_pkg::DIV_4: tap_index = 2'h1;
      rfcp_pkg::DIV_8: tap_index = 2'h2;
      default: tap_index = 2'h3;
    endcase
  endfunction : tap_index

  // codes above 4 fall back to the slowest ratio, divide by 16
  always_comb
  begin
    s_next = s_reg;
    if (xtal_rise)
    begin
      s_next.cnt = s_reg.cnt + 4'h1;
    end
    if (ratio == rfcp_pkg::DIV_1)
    begin
      s_next.clk_out = xtal_level;
    end
    else
    begin
      s_next.clk_out = s_reg.cnt[tap_index(ratio)];
    end
  end

  always_ff @(posedge clock or posedge reset)
  begin
    if (reset)
    begin
      s_reg <= '0;
    end
    else if (clock_enable)
    begin
      s_reg <= s_next;
    end
  end

  assign div_clk = s_reg.clk_out;

  div_count_a: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && xtal_rise) |=> s_reg.cnt == $past(s_reg.cnt) + 4'h1)
    else $error("crystal edge count did not advance");
  div_tap_a: assert property (@(posedge clock) disable iff (reset)
    (clock_enable && ratio == rfcp_pkg::DIV_16) |=> s_reg.clk_out == $past(s_reg.cnt[3]))
    else $error("divide by 16 output wrong");
endmodule : rfcp_clock_divider

// File: tb/rfcp_host_model.sv
`timescale 1ns/1ns
module rfcp_host_model (
  input wire logic clock, // bench clock
  input wire logic sdo, // read data from the device
  output logic select_n, // device select, active low
  output logic sclk, // serial clock, idle low
  output logic sdi // serial data to the device
);
  int half = 6;
  initial
  begin
    select_n = 1'b1;
    sclk = 1'b0;
    sdi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask : tick
  // half periods of at least six clocks keep the phase and gap limits
  task automatic frame(input logic v);
    tick(half);
    select_n = v;
    // released data line must not look like a held bit
    if (v)
      sdi = ~sdi;
    tick(half);
  endtask : frame
  task automatic bits(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--)
    begin
      sdi = tx[i]; // msb first
      tick(half);
      rx[i] = sdo;
      sclk = 1'b1;
      tick(half);
      sclk = 1'b0;
    end
  endtask : bits
endmodule : rfcp_host_model

// File: tb/spi_command_port_with_gpo_bench.sv
`timescale 1ns/1ns
module spi_command_port_with_gpo_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic xtal = 1'b0;
  logic lock = 1'b0;
  logic [2:0] freq = 3'h0;
  logic [2:0] div = 3'h0;
  logic g1u = 1'b0, g1l = 1'b0, g2u = 1'b0, g2l = 1'b0;
  logic ce = 1'b1;
  logic sel_n, sclk, sdi, p1, p2, mrst_n, smode;
  logic [7:0] mem [256];
  logic [31:0] rng = 32'hB32AFC7D;
  int miscompares = 0;
  int tests_run = 0;
  always #5 clock = ~clock;
  // crystal edges land on falling clock edges, ten clocks a period
  always #50 xtal = ~xtal;
  initial
  begin
    #500000;
    miscompares++;
    $display("[ERR] run length expected done seen hang");
    stop_test();
  end
  rfcp_command_port rfcp_command_port_inst (
    .clock(clock), .reset(reset), .clock_enable(ce), .device_select_n(sel_n),
    .serial_clock_pin(sclk), .serial_in_pin(sdi), .freq_select_bit2(freq[2]),
    .freq_select_bit1(freq[1]), .freq_select_bit0(freq[0]), .crystal_clock_pin(xtal),
    .lock_detect_pin(lock), .first_pin_use_level(g1u), .first_pin_level(g1l),
    .clock_div_code(div),
    .gpo2_use_level(g2u), .gpo2_level(g2l), .first_output_pin(p1),
    .second_output_pin(p2), .master_reset_n(mrst_n), .serial_mode(smode));
  rfcp_host_model rfcp_host_model_inst (
    .clock(clock), .sdo(p2), .select_n(sel_n), .sclk(sclk), .sdi(sdi));
  function automatic logic [7:0] rnd8();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng[7:0];
  endfunction : rnd8
  function automatic logic [7:0] exp_period(input logic [2:0] code);
    return (code > 3'h4) ? 8'hA0 : 8'h0A << code;
  endfunction : exp_period
  task automatic chk_byte(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_byte
  task automatic chk_bit(input string name, input logic exp, input logic got);
    tests_run++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %b seen %b", name, exp, got);
    end
  endtask : chk_bit
  task automatic end_test(input string name);
    $display("test %s done", name);
  endtask : end_test
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    rfcp_host_model_inst.bits(tx, 8, rx);
  endtask : xfer
  task automatic sel(input logic v);
    rfcp_host_model_inst.frame(v);
  endtask : sel
  task automatic settle();
    repeat (5) @(negedge clock);
  endtask : settle
  task automatic wr(input logic [7:0] a, input int n);
    logic [7:0] rx, d;
    sel(1'b0);
    xfer(rfcp_pkg::CMD_WRITE, rx); // write opcode
    xfer(a, rx);
    for (int i = 0; i < n; i++)
    begin
      d = rnd8();
      xfer(d, rx);
      mem[a + i[7:0]] = d; // address steps by one and wraps
    end
    sel(1'b1);
  endtask : wr
  task automatic rd(input logic [7:0] q[$]);
    logic [7:0] rx, prev;
    sel(1'b0);
    xfer(rfcp_pkg::CMD_READ, rx);
    chk_byte("read filler", 8'h00, rx);
    foreach (q[i])
    begin
      xfer(q[i], rx);
      chk_byte("read data", (i == 0) ? 8'h00 : mem[prev], rx);
      prev = q[i];
    end
    xfer(rfcp_pkg::FILL_BYTE, rx); // closing byte
    chk_byte("read last", mem[prev], rx);
    sel(1'b1);
  endtask : rd
  task automatic rdall(input logic [7:0] a, input int n1, input int n2);
    logic [7:0] rx;
    sel(1'b0);
    xfer(rfcp_pkg::CMD_READ_ALL, rx);
    xfer(a, rx);
    chk_byte("stream filler", 8'h00, rx);
    for (int i = 0; i < n1 + n2; i++)
    begin
      if (i == n1)
      begin
        sel(1'b1);
        sel(1'b0);
      end
      xfer(rfcp_pkg::FILL_BYTE, rx);
      chk_byte("stream data", mem[a], rx);
      a++;
    end
    sel(1'b1);
  endtask : rdall
  task automatic wait_rise(output int n);
    logic last;
    last = p1;
    for (n = 1; n <= 400; n++)
    begin
      @(negedge clock);
      if (!last && p1)
        return;
      last = p1;
    end
    miscompares++;
    $display("[ERR] first pin edge expected rise seen none");
    stop_test();
  endtask : wait_rise
  initial
  begin
    logic [7:0] a, rx;
    logic [7:0] q[$];
    int cnt;
    foreach (mem[i])
      mem[i] = 8'h00;
    repeat (3) @(negedge clock);
    reset = 1'b0;
    settle();
    chk_bit("serial mode", 1'b1, smode); // pins all low
    chk_bit("master reset", 1'b1, mrst_n);
    end_test("idle");
    // first burst crosses the top address
    for (int t = 0; t < 6; t++)
    begin
      rfcp_host_model_inst.half = 6 + rnd8() % 4;
      a = (t == 0) ? 8'hFD : rnd8();
      wr(a, (t == 0) ? 6 : 1 + rnd8() % 6); // bytes per period
      q = {};
      repeat (4) q.push_back(a + rnd8() % 8); // any order
      rd(q);
    end
    end_test("write read");
    rdall(8'hFE, 2, 3); // wraps at top
    rdall(a, 1, 2);
    end_test("stream");
    a = rnd8();
    sel(1'b0);
    xfer(rfcp_pkg::CMD_WRITE, rx);
    xfer(a, rx);
    xfer(8'h5A, rx);
    mem[a] = 8'h5A;
    rfcp_host_model_inst.bits(8'hC3, 4, rx);
    sel(1'b1); // half byte dropped
    sel(1'b0);
    xfer(8'hA5, rx); // unknown command: rest of the period ignored
    xfer(a, rx);
    xfer(~mem[a], rx);
    sel(1'b1);
    q = {a + 8'h01, a};
    rd(q);
    end_test("abort");
    sel(1'b0);
    xfer(rfcp_pkg::CMD_RESET, rx);
    repeat (4) @(negedge clock);
    chk_bit("master reset", 1'b0, mrst_n);
    sel(1'b1);
    chk_bit("master reset", 1'b0, mrst_n); // held
    sel(1'b0);
    chk_bit("master reset", 1'b1, mrst_n);
    sel(1'b1);
    end_test("reset command");
    freq = 3'h1 + rnd8() % 7; // manual mode
    settle();
    chk_bit("serial mode", 1'b0, smode);
    for (int l = 0; l < 2; l++)
    begin
      lock = l[0];
      settle();
      chk_bit("first pin", lock, p1);
    end
    // lock stays high from here; the write that follows is dropped while manual
    sel(1'b0);
    xfer(rfcp_pkg::CMD_WRITE, rx);
    xfer(a, rx);
    xfer(~mem[a], rx);
    sel(1'b1);
    freq = 3'h0;
    settle();
    q = {a};
    rd(q); // ignored while manual
    end_test("manual");
    for (int i = 0; i < 4; i++)
    begin
      g2u = i[1];
      g2l = i[0];
      lock = ~i[0];
      g1u = 1'b1;
      g1l = i[0];
      settle();
      chk_bit("second pin", g2u ? g2l : lock, p2);
      chk_bit("first pin", g1l, p1);
    end
    ce = 1'b0;
    g1l = ~g1l;
    settle();
    chk_bit("frozen first pin", ~g1l, p1);
    ce = 1'b1;
    settle();
    chk_bit("first pin", g1l, p1);
    end_test("general outputs");
    g1u = 1'b0;
    // only the bench loads the clock pin, so no buffer is modelled
    for (int c = 0; c < 6; c++)
    begin
      div = (c == 5) ? 3'h7 : c[2:0];
      wait_rise(cnt);
      wait_rise(cnt);
      wait_rise(cnt);
      chk_byte("clock period", exp_period(div), cnt[7:0]);
    end
    end_test("divided clock");
    stop_test();
  end
endmodule : spi_command_port_with_gpo_bench
